// ### core/actuator_io_pkg.sv
package actuator_io_pkg;
  localparam int unsigned ADC_W = 12;
  localparam int unsigned TEMP_W = 12;
  localparam int unsigned NCH = 4;
  // channel indices
  localparam int unsigned CH_AIR = 0;
  localparam int unsigned CH_FUEL1 = 1;
  localparam int unsigned CH_FUEL2 = 2;
  localparam int unsigned CH_RECIRC = 3;
  // manual pot scaling, ohms, and loop-equivalent codes
  localparam int unsigned POT_LO_OHM = 200;
  localparam int unsigned POT_HI_OHM = 4500;
  localparam logic [ADC_W-1:0] LOOP_4MA = 12'h333;
  localparam logic [ADC_W-1:0] LOOP_20MA = 12'hFFF;
  // temperature endpoint limits in degF, signed two's complement
  localparam int TEMP_MIN_F = -40;
  localparam int TEMP_MAX_F = 1400;
  localparam int TEMP_MIN_SPAN_F = 100;
  localparam logic [ADC_W-1:0] POS_TOL = 12'h010;
  localparam int unsigned RESET_MIN_NS = 1000000;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {DRV_HOLD, DRV_ADV, DRV_REV} drive_e;

  typedef struct packed {
    logic [ADC_W-1:0] wiper;
    logic [ADC_W-1:0] end_cw;
    logic [ADC_W-1:0] end_ccw;
  } feedback_s;

  typedef struct packed {
    logic p;
    logic n;
  } drive_pair_s;
endpackage : actuator_io_pkg

// ### core/burner_actuator_io_control.sv
module burner_actuator_io_control
  import actuator_io_pkg::*;
#(
  parameter int unsigned RESET_CYC = RESET_MIN_CYC
)(
  input wire logic i_clk_sys, // 50 MHz
  input wire logic i_rst_b, // async, active low
  input wire logic i_remote_reset_in, // pushbutton, high while pressed
  input wire logic [12:0] i_manual_pot_in, // pot resistance in ohms
  input wire logic [ADC_W-1:0] i_firing_rate_loop, // loop code, 4..20 mA
  input wire logic [ADC_W-1:0] i_temp_sensor_loop, // sensor loop code
  input wire logic signed [TEMP_W:0] i_temp_lo_f, // programmed low endpoint degF
  input wire logic signed [TEMP_W:0] i_temp_hi_f, // programmed high endpoint degF
  input wire logic i_pot_is_max_limit, // manual pot used as max limit
  input wire logic i_auto_manual, // manual rate source
  input wire logic i_modulate, // main valve on, modulation phase
  input wire logic i_purge_cmd_in, // purge command
  input wire logic i_lightoff_cmd_in, // light-off command
  input wire logic i_limit_ctrl_in, // limits met and demand
  input wire logic i_fuel_two_sel, // fuel 2 selected
  input wire logic [NCH-1:0] i_ch_cfg, // channel configured
  input wire feedback_s [NCH-1:0] i_feedback, // pot terminals per channel
  input wire logic [NCH-1:0][ADC_W-1:0] i_purge_pos, // purge targets
  input wire logic [NCH-1:0][ADC_W-1:0] i_lightoff_pos, // light-off targets
  input wire logic [NCH-1:0][ADC_W-1:0] i_run_pos, // modulation targets
  output logic o_purge_proved_out, // purge proved contact
  output logic o_lightoff_proved_out, // light-off proved contact
  output logic o_limit_ctrl_out, // burner control power
  output logic o_alarm_out, // halted
  output logic o_temp_cfg_ok, // temperature endpoints accepted
  output logic o_reset_req, // one-cycle reset request
  output logic [ADC_W-1:0] o_rate_cmd, // selected firing rate
  output drive_pair_s [NCH-1:0] o_drive // per channel p/n pair
);
  logic [ADC_W-1:0] pot_code;
  logic [ADC_W-1:0] rate_d, rate_q;
  logic [NCH-1:0][ADC_W-1:0] pos;
  logic [NCH-1:0] at_purge, at_light;
  logic purge_d, purge_q, light_d, light_q, lco_d, lco_q, tcfg_d, tcfg_q;
  logic halt_d, halt_q, init_d, init_q, rr_d, rr_q, req_d, req_q, tok_d, tok_q;
  logic [31:0] hold_cnt_d, hold_cnt_q;
  logic signed [TEMP_W+1:0] span;
  drive_pair_s [NCH-1:0] drv_d, drv_q;
  logic [NCH-1:0] sel_fuel;

  // linear scale, clamped at both ends
  always_comb
  begin
    logic [31:0] ohm;
    ohm = 32'(i_manual_pot_in);
    if (ohm <= POT_LO_OHM)
      pot_code = LOOP_4MA;
    else if (ohm >= POT_HI_OHM)
      pot_code = LOOP_20MA;
    else
      pot_code = ADC_W'(32'(LOOP_4MA) + ((ohm - POT_LO_OHM) * 32'(LOOP_20MA - LOOP_4MA))
        / (POT_HI_OHM - POT_LO_OHM));
  end

  // span needs strict excess over the minimum
  assign span = (TEMP_W+2)'(i_temp_hi_f) - (TEMP_W+2)'(i_temp_lo_f);

  // position is wiper relative to ccw end over ends span, scaled to full code range
  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
      logic [ADC_W-1:0] tgt, off, rng;
      always_comb
      begin
        off = (i_feedback[c].wiper > i_feedback[c].end_ccw) ?
          i_feedback[c].wiper - i_feedback[c].end_ccw : '0;
        rng = (i_feedback[c].end_cw > i_feedback[c].end_ccw) ?
          i_feedback[c].end_cw - i_feedback[c].end_ccw : '0;
        // scaled to full code range so a shortened pot travel still spans it
        if (rng == '0)
          pos[c] = '0;
        else if (off >= rng)
          pos[c] = '1;
        else
          pos[c] = ADC_W'((32'(off) * 32'({ADC_W{1'b1}})) / 32'(rng));
        at_purge[c] = (pos[c] >= i_purge_pos[c] ? pos[c] - i_purge_pos[c]
          : i_purge_pos[c] - pos[c]) <= POS_TOL;
        at_light[c] = (pos[c] >= i_lightoff_pos[c] ? pos[c] - i_lightoff_pos[c]
          : i_lightoff_pos[c] - pos[c]) <= POS_TOL;
        if (i_purge_cmd_in)
          tgt = i_purge_pos[c];
        else if (i_lightoff_cmd_in)
          tgt = i_lightoff_pos[c];
        else
          tgt = i_run_pos[c];
        // hold when unconfigured, halted, in the start window, or on target
        if (!i_ch_cfg[c] || halt_q || init_q ||
            (pos[c] >= tgt ? pos[c] - tgt : tgt - pos[c]) <= POS_TOL)
          drv_d[c] = '{p: 1'b0, n: 1'b0};
        else if (tgt > pos[c])
          drv_d[c] = '{p: 1'b1, n: 1'b0};
        else
          drv_d[c] = '{p: 1'b0, n: 1'b1};
      end
    end
  endgenerate

  always_comb
  begin
    sel_fuel = i_fuel_two_sel ? (NCH'(1) << CH_FUEL2) : (NCH'(1) << CH_FUEL1);
    // request on release, after a press
    rr_d = i_remote_reset_in;
    req_d = rr_q && !i_remote_reset_in;
    // power-up interlock window
    hold_cnt_d = hold_cnt_q;
    init_d = init_q;
    tok_d = tok_q;
    halt_d = halt_q;
    if (init_q)
    begin
      if (i_purge_cmd_in && i_lightoff_cmd_in)
        tok_d = 1'b0;
      if (hold_cnt_q >= RESET_CYC - 1)
      begin
        init_d = 1'b0;
        halt_d = !tok_d;
      end
      else
        hold_cnt_d = hold_cnt_q + 32'd1;
    end
    else if (i_purge_cmd_in && i_lightoff_cmd_in)
      halt_d = 1'b1;
    if (req_q)
    begin
      init_d = 1'b1;
      hold_cnt_d = '0;
      // both commands in the restart cycle still spoil the new window
      tok_d = !(i_purge_cmd_in && i_lightoff_cmd_in);
    end
    rate_d = i_firing_rate_loop;
    if (i_modulate && i_auto_manual && !i_pot_is_max_limit)
      rate_d = pot_code;
    else if (i_pot_is_max_limit && i_firing_rate_loop > pot_code)
      rate_d = pot_code;
    purge_d = i_purge_cmd_in && !halt_q && !init_q && at_purge[CH_AIR] &&
      (|(at_purge & sel_fuel)) && (at_purge[CH_RECIRC] || !i_ch_cfg[CH_RECIRC]);
    light_d = i_lightoff_cmd_in && !halt_q && !init_q && at_light[CH_AIR] &&
      (|(at_light & sel_fuel)) && (at_light[CH_RECIRC] || !i_ch_cfg[CH_RECIRC]);
    lco_d = i_limit_ctrl_in && !halt_q && !init_q;
    tcfg_d = (i_temp_lo_f >= (TEMP_W+1)'(TEMP_MIN_F)) && (i_temp_hi_f <= (TEMP_W+1)'(TEMP_MAX_F))
      && (span > (TEMP_W+2)'(TEMP_MIN_SPAN_F));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rr_q <= 1'b0;
      req_q <= 1'b0;
      init_q <= 1'b1;
      tok_q <= 1'b1;
      halt_q <= 1'b0;
      hold_cnt_q <= '0;
      rate_q <= '0;
      purge_q <= 1'b0;
      light_q <= 1'b0;
      lco_q <= 1'b0;
      tcfg_q <= 1'b0;
      drv_q <= '0;
    end
    else
    begin
      rr_q <= rr_d;
      req_q <= req_d;
      init_q <= init_d;
      tok_q <= tok_d;
      halt_q <= halt_d;
      hold_cnt_q <= hold_cnt_d;
      rate_q <= rate_d;
      purge_q <= purge_d;
      light_q <= light_d;
      lco_q <= lco_d;
      tcfg_q <= tcfg_d;
      drv_q <= drv_d;
    end
  end

  assign o_purge_proved_out = purge_q;
  assign o_lightoff_proved_out = light_q;
  assign o_limit_ctrl_out = lco_q;
  assign o_alarm_out = halt_q;
  assign o_reset_req = req_q;
  assign o_rate_cmd = rate_q;
  assign o_drive = drv_q;
  assign o_temp_cfg_ok = tcfg_q;

  a_purge_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_purge_cmd_in |=> !o_purge_proved_out) else $error("purge proved without command");
  a_light_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_lightoff_cmd_in |=> !o_lightoff_proved_out) else $error("light-off proved without command");
  a_lco_needs_lci: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_limit_ctrl_in |=> !o_limit_ctrl_out) else $error("limit out without limit in");
  a_both_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_purge_cmd_in && i_lightoff_cmd_in && !init_q) |=> ##1 (o_alarm_out && !o_limit_ctrl_out))
    else $error("both commands did not halt");
  a_reset_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $fell(i_remote_reset_in) |=> o_reset_req ##1 !o_reset_req) else $error("reset request missing");
  a_pot_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_modulate && i_auto_manual && !i_pot_is_max_limit && i_manual_pot_in <= 13'(POT_LO_OHM))
    |=> o_rate_cmd == LOOP_4MA) else $error("low pot not 4 mA");
  a_max_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_pot_is_max_limit |=> o_rate_cmd <= $past(pot_code)) else $error("rate above limit");
  a_unconf_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_ch_cfg[CH_RECIRC] |=> o_drive[CH_RECIRC] == '0) else $error("unconfigured channel moving");
  a_pair_excl: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(o_drive[CH_AIR].p && o_drive[CH_AIR].n)) else $error("both pair halves on");
  c_purge: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_purge_proved_out));
  c_light: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_lightoff_proved_out));
  c_halt: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_alarm_out));
  a_init_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    init_q |=> (o_drive == '0 && !o_limit_ctrl_out && !o_purge_proved_out && !o_lightoff_proved_out))
    else $error("output active during start window");
  c_reset: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_reset_req));
endmodule : burner_actuator_io_control

// ### testbench/actuator_model.sv
module actuator_model
  import actuator_io_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire drive_pair_s [NCH-1:0] i_drive, // drive pairs from the block
  output feedback_s [NCH-1:0] o_feedback // pot terminals per channel
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [ADC_W-1:0] END_LO = 12'h020;
  logic [NCH-1:0][ADC_W-1:0] pos_q;
  initial pos_q = '0;
  // eight codes a cycle: smaller than the band, so a correct loop settles
  always @(posedge i_clk_sys)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (i_drive[c] == 2'b10) pos_q[c] <= pos_q[c] + 12'h008;
      else if (i_drive[c] == 2'b01 && pos_q[c] >= 12'h008) pos_q[c] <= pos_q[c] - 12'h008;
    end
  end
  // ccw end offset from zero so the block must subtract it
  always_comb
    for (int c = 0; c < NCH; c++)
      o_feedback[c] = '{wiper: pos_q[c] + END_LO, end_cw: 12'hFFF, end_ccw: END_LO};
endmodule : actuator_model

// ### testbench/burner_actuator_io_control_test.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module burner_actuator_io_control_test
  import actuator_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [12:0] pot; logic [11:0] loop; logic mx, am, md;
    logic signed [12:0] lo, hi; logic [11:0] rate; logic ok;
  } row_s;
  row_s rows [7] = '{
    '{13'h0064, 12'h800, 1'b0, 1'b0, 1'b1, 13'h1FD8, 13'h0578, 12'h800, 1'b1},
    '{13'h0064, 12'h800, 1'b0, 1'b1, 1'b1, 13'h1FD7, 13'h0578, 12'h333, 1'b0},
    '{13'h125C, 12'h800, 1'b0, 1'b1, 1'b1, 13'h0000, 13'h0579, 12'hFFF, 1'b0},
    '{13'h125C, 12'h555, 1'b0, 1'b1, 1'b0, 13'h0000, 13'h0064, 12'h555, 1'b0},
    '{13'h00C8, 12'h800, 1'b1, 1'b0, 1'b1, 13'h0000, 13'h0065, 12'h333, 1'b1},
    '{13'h1194, 12'h800, 1'b1, 1'b1, 1'b1, 13'h01F4, 13'h0190, 12'h800, 1'b0},
    '{13'h092E, 12'h800, 1'b0, 1'b1, 1'b1, 13'h0000, 13'h0065, 12'h999, 1'b1}};
  int err_total = 0;
  int tests_run = 0;
  logic clk = 1'b0, rst_b = 1'b0, rr = 1'b0, mx = 1'b0, am = 1'b0, md = 1'b0;
  logic pc = 1'b0, lc = 1'b0, limit_ctrl_in = 1'b0, f2 = 1'b0;
  logic [12:0] pot = '0;
  logic [11:0] loop = 12'h333;
  logic signed [12:0] lo = '0, hi = '0;
  logic [3:0] cfg = '0;
  logic [NCH-1:0][ADC_W-1:0] pp = '0, lp = '0;
  logic purge_proved_out, lightoff_proved_out, limit_ctrl_out, alarm_out, tok, rq;
  logic [11:0] rate;
  drive_pair_s [NCH-1:0] drv;
  feedback_s [NCH-1:0] fb;
  burner_actuator_io_control #(.RESET_CYC(8)) burner_actuator_io_control_inst (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_remote_reset_in(rr), .i_manual_pot_in(pot),
    .i_firing_rate_loop(loop), .i_temp_sensor_loop(12'h333), .i_temp_lo_f(lo), .i_temp_hi_f(hi),
    .i_pot_is_max_limit(mx), .i_auto_manual(am), .i_modulate(md), .i_purge_cmd_in(pc),
    .i_lightoff_cmd_in(lc), .i_limit_ctrl_in(limit_ctrl_in), .i_fuel_two_sel(f2), .i_ch_cfg(cfg),
    .i_feedback(fb), .i_purge_pos(pp), .i_lightoff_pos(lp), .i_run_pos('0),
    .o_purge_proved_out(purge_proved_out), .o_lightoff_proved_out(lightoff_proved_out), .o_limit_ctrl_out(limit_ctrl_out),
    .o_alarm_out(alarm_out), .o_temp_cfg_ok(tok), .o_reset_req(rq), .o_rate_cmd(rate), .o_drive(drv));
  actuator_model actuator_model_inst (.i_clk_sys(clk), .i_drive(drv), .o_feedback(fb));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial
  begin
    #(20 * 20000);
    err_total++;
    finish_test();
  end
  initial
  begin
    cyc(11);
    `CHK({purge_proved_out, lightoff_proved_out, limit_ctrl_out, alarm_out, rq, tok, drv}, '0)
    $display("reset state done");
    @(posedge clk) rst_b <= 1'b1;
    cyc(12);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk) {pot, loop, mx, am, md, lo, hi} <= rows[i][66:13];
      cyc(2);
      `CHK(rate, rows[i].rate)
      `CHK(tok, rows[i].ok)
      $display("row %0d done", i);
    end
    @(posedge clk) limit_ctrl_in <= 1'b1;
    cyc(2);
    `CHK(limit_ctrl_out, 1'b1)
    $display("limit out done");
    // recirc left unconfigured: purge must prove without it
    @(posedge clk)
    begin
      cfg <= 4'h7;
      pp <= {12'h400, 12'h300, 12'h200, 12'h100};
      pc <= 1'b1;
    end
    cyc(2);
    `CHK(drv[0], 2'b10)
    `CHK(drv[3], 2'b00)
    for (int n = 0; n < 400 && purge_proved_out !== 1'b1; n++) cyc(1);
    `CHK(purge_proved_out, 1'b1)
    cyc(1);
    `CHK(drv[1], 2'b00)
    @(posedge clk) pc <= 1'b0;
    cyc(1);
    `CHK(purge_proved_out, 1'b0)
    $display("purge done");
    @(posedge clk)
    begin
      f2 <= 1'b1;
      cfg <= 4'hF;
      lp <= {12'h180, 12'h280, 12'h0C0, 12'h080};
      lc <= 1'b1;
    end
    cyc(2);
    `CHK(drv[0], 2'b01)
    for (int n = 0; n < 400 && lightoff_proved_out !== 1'b1; n++) cyc(1);
    `CHK(lightoff_proved_out, 1'b1)
    `CHK(purge_proved_out, 1'b0)
    $display("light-off done");
    @(posedge clk) pc <= 1'b1;
    cyc(2);
    `CHK(alarm_out, 1'b1)
    cyc(1);
    `CHK({limit_ctrl_out, lightoff_proved_out}, 2'b00)
    @(posedge clk)
    begin
      pc <= 1'b0;
      lc <= 1'b0;
      rr <= 1'b1;
    end
    @(posedge clk) rr <= 1'b0;
    for (int n = 0; n < 10 && rq !== 1'b1; n++) cyc(1);
    `CHK(rq, 1'b1)
    cyc(1);
    `CHK(rq, 1'b0)
    cyc(11);
    `CHK({alarm_out, limit_ctrl_out}, 2'b01)
    $display("halt and remote reset done");
    // both commands present through a fresh start: start refused
    @(posedge clk)
    begin
      pc <= 1'b1;
      lc <= 1'b1;
      rst_b <= 1'b0;
    end
    cyc(2);
    @(posedge clk) rst_b <= 1'b1;
    cyc(2);
    @(posedge clk) {pc, lc} <= 2'b00;
    cyc(12);
    `CHK({alarm_out, limit_ctrl_out}, 2'b10)
    $display("power-up refusal done");
    finish_test();
  end
endmodule : burner_actuator_io_control_test
